// *** hw/capture_timer_pkg.sv ***
// package: register map, field layout, reset values and timing counts of the capture timer
package capture_timer_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_TIMER_MODE  = 16'hFFBC;
  localparam logic [15:0] IDX_CAPTURE     = 16'hFFBE;
  localparam logic [15:0] IDX_PORT_MODE1  = 16'hFFC8;
  localparam logic [15:0] IDX_PORT_MODE2  = 16'hFFC9;
  localparam logic [15:0] IDX_IRQ_ENABLE2 = 16'hFFF4;
  localparam logic [15:0] IDX_IRQ_REQ2    = 16'hFFF7;
  localparam int          ADDR_W          = 18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_PIN_SEL   = 3;  // port_mode_one: shared pin feeds capture input
  localparam int BIT_NOISE_SEL = 1;  // port_mode_two: noise filter in path
  localparam int BIT_TIMER_IRQ = 4;  // enable / request bit of the timer

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [1:0] CLR_ON_RISE  = 2'h2;
  localparam logic [1:0] CKS_DIV64    = 2'h0;
  localparam logic [7:0] CNT_MAX      = 8'hFF;

  // ----------------------------------------------------------------
  // timing counts (system clock cycles)
  // ----------------------------------------------------------------
  localparam logic [5:0] MASK_DIV64   = 6'h3F;
  localparam logic [5:0] MASK_DIV32   = 6'h1F;
  localparam logic [5:0] MASK_DIV16   = 6'h0F;
  localparam logic [5:0] MASK_DIV4    = 6'h03;
  localparam logic [2:0] FILTER_LAST  = 3'h3;  // four agreeing samples pass the filter

  typedef struct packed {
    logic       ovf_hi;     // overflow_flag_high
    logic       ovf_lo;     // overflow_flag_low
    logic       ovf_ie;     // overflow_irq_enable
    logic       edge_sel;   // capture_edge_sel
    logic [1:0] clear_sel;  // clear_sel_hi, clear_sel_lo
    logic [1:0] clk_sel;    // clk_sel_hi, clk_sel_lo
  } timer_mode_t;

  typedef struct packed {
    logic rise;             // filtered capture input rose
    logic fall;             // filtered capture input fell
    logic level;            // filtered capture input level
  } capture_evt_t;

endpackage

// *** hw/capture_prescaler.sv ***
// prescaler: free-running divider that gives the counter tick for the selected rate
`timescale 1ns/1ps
`default_nettype none
module capture_prescaler
  import capture_timer_pkg::*;
(
  input  wire logic       pclk,     // system clock
  input  wire logic       presetn,  // async reset, active low
  input  wire logic [1:0] clk_sel,  // rate select
  output logic            tick      // one-cycle counter advance
);

  logic [5:0] div_q;
  logic [5:0] mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  always_comb begin
    unique case (clk_sel)
      2'h0: mask = MASK_DIV64;
      2'h1: mask = MASK_DIV32;
      2'h2: mask = MASK_DIV16;
      2'h3: mask = MASK_DIV4;
    endcase
  end

  assign tick = ((div_q & mask) == mask);

  AST_DIV64_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && clk_sel == CKS_DIV64) |=> (!tick || clk_sel != CKS_DIV64) [*8])
    else $error("tick repeated too soon at divide by 64");

endmodule
`default_nettype wire

// *** hw/capture_sync_filter.sv ***
// capture input conditioning: three-stage synchroniser and optional noise filter
`timescale 1ns/1ps
`default_nettype none
module capture_sync_filter
  import capture_timer_pkg::*;
(
  input  wire logic   pclk,     // system clock
  input  wire logic   presetn,  // async reset, active low
  input  wire logic   raw_in,   // asynchronous capture level
  input  wire logic   nf_en,    // noise filter inserted
  output capture_evt_t evt      // filtered level and edges
);

  logic       s1_q, s2_q, s3_q;
  logic       level_q;
  logic       prev_q;
  logic [2:0] agree_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // filter bypass or insert
  // a change counts only when stages two and three agree; with the filter on it
  // must also persist, which trades three cycles of latency for glitch immunity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      agree_q <= 3'h0;
    end else if (s2_q == s3_q && s3_q != level_q) begin
      if (!nf_en || agree_q == FILTER_LAST) begin
        level_q <= s3_q;
        agree_q <= 3'h0;
      end else begin
        agree_q <= agree_q + 3'h1;
      end
    end else begin
      agree_q <= 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_q;
    end
  end

  assign evt.level = level_q;
  assign evt.rise  = level_q & ~prev_q;
  assign evt.fall  = ~level_q & prev_q;

  AST_FILTER_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(nf_en) && $changed(level_q)) |-> ($past(agree_q) == FILTER_LAST))
    else $error("filtered level changed before the filter settled");

endmodule
`default_nettype wire

// *** hw/input_capture_timer.sv ***
// input capture timer: 8-bit prescaled counter, capture register, pin routing and apb registers
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module input_capture_timer
  import capture_timer_pkg::*;
(
  input  wire logic              pclk,      // system clock, 125 MHz
  input  wire logic              presetn,   // async reset, active low
  input  wire logic              psel,      // apb select
  input  wire logic              penable,   // apb access phase
  input  wire logic              pwrite,    // apb direction
  input  wire logic [ADDR_W-1:0] paddr,     // apb byte address
  input  wire logic [31:0]       pwdata,    // apb write data
  input  wire logic [3:0]        pstrb,     // apb byte strobes
  output logic                   pready,    // apb ready
  output logic [31:0]            prdata,    // apb read data
  output logic                   pslverr,   // apb error, unmapped address
  input  wire logic              pin_in,    // shared port pin level
  output logic                   pin_out,   // shared port pin drive value
  output logic                   pin_oe,    // shared port pin output enable
  input  wire logic              port_dout, // port logic drive value
  input  wire logic              port_dir,  // port logic direction, 1 drives
  output logic                   port_din,  // pin level seen by port logic
  output logic                   irq        // timer interrupt, level
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  timer_mode_t  mode_q;
  logic [7:0]   counter_q;
  logic [7:0]   capture_q;
  logic [7:0]   port_mode1_q;
  logic [7:0]   port_mode2_q;
  logic [7:0]   irq_en_q;
  logic [7:0]   irq_req_q;
  logic [31:0]  prdata_q;
  capture_evt_t evt;
  logic         tick;
  logic         cap_raw;
  logic         pin_sel;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [15:0] idx;
  logic        hit;
  logic        wr_en;
  logic        rd_setup;
  logic        wr_mode, wr_pm1, wr_pm2, wr_ien, wr_irr;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;

  // offsets are register indices, so the byte address is four times the index
  assign idx      = paddr[ADDR_W-1:2];
  assign wbyte    = pwdata[7:0];
  assign hit      = (idx == IDX_TIMER_MODE) || (idx == IDX_CAPTURE) || (idx == IDX_PORT_MODE1) ||
                    (idx == IDX_PORT_MODE2) || (idx == IDX_IRQ_ENABLE2) || (idx == IDX_IRQ_REQ2);
  assign wr_en    = psel && penable && pwrite && pstrb[0] && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_mode  = wr_en && (idx == IDX_TIMER_MODE);
  assign wr_pm1   = wr_en && (idx == IDX_PORT_MODE1);
  assign wr_pm2   = wr_en && (idx == IDX_PORT_MODE2);
  assign wr_ien   = wr_en && (idx == IDX_IRQ_ENABLE2);
  assign wr_irr   = wr_en && (idx == IDX_IRQ_REQ2);

  // zero-wait slave; read data is caught in the setup phase so it leaves a flop
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_q;

  always_comb begin
    unique case (idx)
      IDX_TIMER_MODE:  rbyte = mode_q;
      IDX_CAPTURE:     rbyte = capture_q;
      IDX_PORT_MODE1:  rbyte = port_mode1_q;
      IDX_PORT_MODE2:  rbyte = port_mode2_q;
      IDX_IRQ_ENABLE2: rbyte = irq_en_q;
      IDX_IRQ_REQ2:    rbyte = irq_req_q;
      default:         rbyte = RST_BYTE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= {24'h00_0000, rbyte};
    end
  end

  // ----------------------------------------------------------------
  // pin routing and input conditioning
  // ----------------------------------------------------------------
  // pin function switch
  assign pin_sel  = port_mode1_q[BIT_PIN_SEL];
  assign pin_oe   = !pin_sel && port_dir;
  assign pin_out  = port_dout;
  assign port_din = pin_in;
  // with the pin given to the port the capture path sees a quiet low level
  assign cap_raw  = pin_sel && pin_in;

  capture_sync_filter u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (cap_raw),
    .nf_en   (port_mode2_q[BIT_NOISE_SEL]),
    .evt     (evt)
  );

  capture_prescaler u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_sel (mode_q.clk_sel),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // counter and capture
  // ----------------------------------------------------------------
  logic clr_evt;
  logic ovf_evt;
  logic cap_irq_evt;

  assign clr_evt     = evt.rise && (mode_q.clear_sel == CLR_ON_RISE);
  assign ovf_evt     = tick && !clr_evt && (counter_q == CNT_MAX);
  assign cap_irq_evt = mode_q.edge_sel ? evt.fall : evt.rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_q <= 8'h00;
    end else if (clr_evt) begin
      counter_q <= 8'h00;
    end else if (tick) begin
      counter_q <= counter_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_q <= 8'h00;
    end else if (evt.rise) begin
      capture_q <= counter_q;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // only strobe bit 0 gates a write, since each register holds one byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_mode1_q <= RST_BYTE;
      port_mode2_q <= RST_BYTE;
      irq_en_q     <= RST_BYTE;
    end else begin
      if (wr_pm1) port_mode1_q <= wbyte;
      if (wr_pm2) port_mode2_q <= wbyte;
      if (wr_ien) irq_en_q <= wbyte;
    end
  end

  // overflow flags are written one-to-clear; a new overflow wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= timer_mode_t'(RST_BYTE);
    end else begin
      if (wr_mode) begin
        mode_q.ovf_ie    <= wbyte[5];
        mode_q.edge_sel  <= wbyte[4];
        mode_q.clear_sel <= wbyte[3:2];
        mode_q.clk_sel   <= wbyte[1:0];
      end
      mode_q.ovf_hi <= (ovf_evt && evt.level) || (mode_q.ovf_hi && !(wr_mode && wbyte[7]));
      mode_q.ovf_lo <= (ovf_evt && !evt.level) || (mode_q.ovf_lo && !(wr_mode && wbyte[6]));
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  logic timer_set;
  assign timer_set = cap_irq_evt || (ovf_evt && mode_q.ovf_ie);

  // request flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_q <= RST_BYTE;
    end else begin
      irq_req_q[BIT_TIMER_IRQ] <= timer_set ||
        (irq_req_q[BIT_TIMER_IRQ] && !(wr_irr && wbyte[BIT_TIMER_IRQ]));
    end
  end

  assign irq = irq_req_q[BIT_TIMER_IRQ] && irq_en_q[BIT_TIMER_IRQ];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_CLEAR_ON_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    (evt.rise && mode_q.clear_sel == CLR_ON_RISE) |=> (counter_q == 8'h00))
    else $error("counter not cleared on capture rise");

  AST_COUNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !clr_evt) |=> (counter_q == $past(counter_q) + 8'h01))
    else $error("counter did not advance by one on tick");

  AST_COUNT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!tick && !clr_evt) |=> $stable(counter_q))
    else $error("counter moved without a tick");

  AST_CAPTURE_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
    evt.rise |=> (capture_q == $past(counter_q)))
    else $error("capture register missed the counter value");

  AST_CAPTURE_RO: assert property (@(posedge pclk) disable iff (!presetn)
    !evt.rise |=> $stable(capture_q))
    else $error("capture register changed without a capture");

  AST_PIN_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
    pin_sel |-> !pin_oe)
    else $error("pin driven while given to the capture input");

  AST_IRQ_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_req_q[BIT_TIMER_IRQ] && !irq_en_q[BIT_TIMER_IRQ]) |-> !irq)
    else $error("masked timer request reached the output");

  AST_EDGE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q.edge_sel ? evt.fall : evt.rise) |=> irq_req_q[BIT_TIMER_IRQ])
    else $error("selected capture edge did not raise the flag");

  AST_OVF_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf_evt && mode_q.ovf_ie) |=> irq_req_q[BIT_TIMER_IRQ])
    else $error("enabled overflow did not raise the flag");

  AST_OVF_SIDE: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_evt |=> ($past(evt.level) ? mode_q.ovf_hi : mode_q.ovf_lo))
    else $error("overflow side flag not set");

  AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_evt |=> (counter_q == 8'h00))
    else $error("counter did not wrap to zero");

  COV_CAPTURE:  cover property (@(posedge pclk) disable iff (!presetn) evt.rise && counter_q != 8'h00);
  COV_OVERFLOW: cover property (@(posedge pclk) disable iff (!presetn) ovf_evt && mode_q.ovf_ie);
  COV_IRQ:      cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  COV_FALL_IRQ: cover property (@(posedge pclk) disable iff (!presetn) cap_irq_evt && mode_q.edge_sel);
  COV_HIGH_OVF: cover property (@(posedge pclk) disable iff (!presetn) ovf_evt && evt.level);

  // ----------------------------------------------------------------
  // register and flag checks
  // ----------------------------------------------------------------
  AST_FLAG_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_irr && wbyte[BIT_TIMER_IRQ] && !timer_set) |=> !irq_req_q[BIT_TIMER_IRQ])
    else $error("timer flag not cleared by writing one");

  AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!timer_set && !(wr_irr && wbyte[BIT_TIMER_IRQ])) |=> $stable(irq_req_q[BIT_TIMER_IRQ]))
    else $error("timer flag moved without an event or a clear");

  AST_OVF_HI_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_mode && wbyte[7] && !(ovf_evt && evt.level)) |=> !mode_q.ovf_hi)
    else $error("high overflow flag not cleared by writing one");

  AST_OVF_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf_evt && !mode_q.ovf_ie && !cap_irq_evt && !irq_req_q[BIT_TIMER_IRQ]) |=> !irq_req_q[BIT_TIMER_IRQ])
    else $error("disabled overflow raised the timer flag");

  AST_ENABLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ien |=> (irq_en_q == $past(wbyte)))
    else $error("interrupt enable write lost");

  AST_MODE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_mode |=> (mode_q.clk_sel == $past(wbyte[1:0]) && mode_q.clear_sel == $past(wbyte[3:2])))
    else $error("timer mode write lost");

  AST_PM1_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pm1 |=> (port_mode1_q == $past(wbyte)))
    else $error("pin function write lost");

  AST_PM2_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pm2 |=> (port_mode2_q == $past(wbyte)))
    else $error("noise filter select write lost");

endmodule
`default_nettype wire

// *** testbench/capture_pulse_src.sv ***
// external pulse source driving the capture level of the shared pin
`timescale 1ns/1ps
`default_nettype none
module capture_pulse_src (
  input  wire logic pclk,  // system clock
  output var  logic level  // source pin level
);
  initial level = 1'b0;

  // ----------------------------------------------------------------
  // drive tasks
  // ----------------------------------------------------------------
  // changes land just after an edge, so the synchroniser never races them
  task automatic set(input logic v);
    @(posedge pclk);
    level <= v;
  endtask

  task automatic pulse(input int w);
    set(1'b1);
    repeat (w) @(posedge pclk);
    level <= 1'b0;
  endtask

  // two rises exactly p cycles apart, so their capture delta is exact
  task automatic pulse2(input int p);
    pulse(8);
    repeat (p - 9) @(posedge pclk);
    pulse(8);
  endtask
endmodule
`default_nettype wire

// *** testbench/input_capture_timer_test.sv ***
// testbench of the input capture timer: apb register tasks and capture scenarios
`timescale 1ns/1ps
`default_nettype none
module input_capture_timer_test;
  import capture_timer_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, port_dout, port_dir;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, r;
  logic [3:0]        pstrb;
  logic              pready, pslverr, pin_out, pin_oe, port_din, irq, src_level, e;
  logic [7:0]        c1;
  logic [15:0]       regs [6] = '{IDX_TIMER_MODE, IDX_CAPTURE, IDX_PORT_MODE1,
                                  IDX_PORT_MODE2, IDX_IRQ_ENABLE2, IDX_IRQ_REQ2};
  int                miscompares = 0;
  int                n_checks = 0;
  wire               pin_wire;

  // the pin follows the design whenever it drives, else the source
  assign pin_wire = pin_oe ? pin_out : src_level;

  input_capture_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pin_in(pin_wire), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_dout(port_dout), .port_dir(port_dir), .port_din(port_din), .irq(irq));
  capture_pulse_src src (.pclk(pclk), .level(src_level));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, idx[1:0]};
    pwdata  <= {idx, idx[7:0], d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    chk(i < 16, "apb timeout");
    if (i >= 16) finish_test();
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hF);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] x, input string m);
    apb(1'b0, idx, 8'h00, 4'hF);
    chk(r === {24'h000000, x} && e === 1'b0, m);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  // bounded wait on the interrupt level; running out ends the run
  task automatic wait_irq(input int n);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < n) begin
      @(negedge pclk);
      i++;
    end
    chk(irq === 1'b1, "interrupt missing");
    if (irq !== 1'b1) finish_test();
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    chk(1'b0, "run timeout");
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = '0;
    pstrb     = '0;
    port_dout = 1'b0;
    port_dir  = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[k]) rd(regs[k], 8'h00, "reset value");
    apb(1'b0, 16'h0000, 8'h00, 4'hF);
    chk(e === 1'b1 && r === 32'h0, "unmapped read");
    wr(IDX_CAPTURE, 8'hFF);
    rd(IDX_CAPTURE, 8'h00, "capture written");
    // port function: design drives the pin, captures stay off
    port_dir  <= 1'b1;
    port_dout <= 1'b1;
    idle(2);
    chk(pin_oe === 1'b1 && pin_out === 1'b1 && port_din === 1'b1, "port drive");
    @(posedge pclk);
    port_dout <= 1'b0;
    idle(2);
    chk(pin_oe === 1'b1 && pin_out === 1'b0 && port_din === 1'b0, "port drive low");
    @(posedge pclk);
    port_dir <= 1'b0;
    wr(IDX_IRQ_ENABLE2, 8'h10);
    src.pulse(8);
    idle(20);
    chk(irq === 1'b0, "capture in port mode");
    apb(1'b1, IDX_PORT_MODE1, 8'h08, 4'hE);
    rd(IDX_PORT_MODE1, 8'h00, "strobe ignored");
    wr(IDX_PORT_MODE1, 8'h08);
    @(posedge pclk);
    port_dir <= 1'b1;
    idle(2);
    chk(pin_oe === 1'b0, "pin still driven");
    // capture delta over exactly five prescaled periods
    fork
      src.pulse2(320);
      begin
        wait_irq(40);
        apb(1'b0, IDX_CAPTURE, 8'h00, 4'hF);
        c1 = r[7:0];
        wr(IDX_IRQ_REQ2, 8'h10);
        idle(1);
        chk(irq === 1'b0, "flag not cleared");
      end
    join
    wait_irq(40);
    apb(1'b0, IDX_CAPTURE, 8'h00, 4'hF);
    chk(r[7:0] - c1 === 8'h05, "capture delta");
    // clear on rise: second capture sees a fresh counter
    wr(IDX_TIMER_MODE, 8'h08);
    wr(IDX_IRQ_REQ2, 8'h10);
    src.pulse2(40);
    wait_irq(40);
    apb(1'b0, IDX_CAPTURE, 8'h00, 4'hF);
    chk(r[7:0] <= 8'h01, "counter not cleared");
    // falling-edge interrupt select
    wr(IDX_TIMER_MODE, 8'h10);
    wr(IDX_IRQ_REQ2, 8'h10);
    src.set(1'b1);
    idle(20);
    chk(irq === 1'b0, "rise flagged");
    src.set(1'b0);
    wait_irq(40);
    // a three-cycle glitch is removed only with the filter in
    wr(IDX_TIMER_MODE, 8'h00);
    wr(IDX_IRQ_REQ2, 8'h10);
    wr(IDX_PORT_MODE2, 8'h02);
    src.pulse(3);
    idle(30);
    chk(irq === 1'b0, "glitch passed filter");
    wr(IDX_PORT_MODE2, 8'h00);
    src.pulse(3);
    wait_irq(40);
    // overflow at divide by four: low flag, no request while disabled
    wr(IDX_IRQ_REQ2, 8'h10);
    wr(IDX_TIMER_MODE, 8'h03);
    idle(1100);
    rd(IDX_TIMER_MODE, 8'h43, "low overflow");
    rd(IDX_IRQ_REQ2, 8'h00, "overflow request while disabled");
    wr(IDX_TIMER_MODE, 8'h53);
    src.set(1'b1);
    idle(8);
    wr(IDX_TIMER_MODE, 8'h73);
    wait_irq(1100);
    rd(IDX_TIMER_MODE, 8'hB3, "high overflow");
    wr(IDX_IRQ_ENABLE2, 8'h00);
    idle(1);
    chk(irq === 1'b0, "masked interrupt");
    wr(IDX_IRQ_ENABLE2, 8'h10);
    idle(1);
    chk(irq === 1'b1, "unmasked interrupt");
    rd(IDX_IRQ_REQ2, 8'h10, "flag reads set");
    wr(IDX_IRQ_REQ2, 8'h10);
    idle(1);
    chk(irq === 1'b0, "flag not cleared");
    finish_test();
  end
endmodule
`default_nettype wire
